// ---- verilog/nhf_pkg.sv ----
// How it works
// - Each sentence opens with a dollar sign and ends with CR then LF.
// - A fixed field sequence sits between start and end, comma separated.
// - Sentences repeat automatically at a programmed rate of 1 to 100 Hz.
// - A sentence due while one is still sending is skipped, never corrupted.
// - Sentences are output only; configuration arrives only over the register bus.
// - Header is P, a three-letter vendor tag, then H for health.
// - Health fields: time, sats, HDOP, mode, flags, reserved, checksum.
// - Time has up to 13 digits, three fractional, uptime or loaded UTC.
// - Satellite counts always print as two characters, ASCII zero plus each nibble of the register.
// - HDOP field prints the value written to the HDOP register over the bus.
// - Mode prints 0 for Euler angles and 1 for quaternions.
// - Overflow flag sets when a sentence is skipped; only reset clears it.
// - Each sensor fault flag holds until that sensor reads successfully.
// - Navigation timeout flag sets after 2 s silence, clears on valid packet.
// - The three reserved fields always print 0.
// - Checksum is XOR of bytes between dollar and asterisk, after asterisk.
// - Baud select spans 9600 to 921600, 115200 after reset.
package nhf_pkg;
    // Characters
    localparam logic [7:0] CH_DOLLAR = 8'h24;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_DOT = 8'h2E;
    localparam logic [7:0] CH_STAR = 8'h2A;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_HEX_A = 8'h37;
    localparam logic [7:0] CH_P = 8'h50;
    localparam logic [7:0] CH_H = 8'h48;
    localparam logic [23:0] VENDOR_TAG = 24'h564E44; // Arbitrary value
    localparam logic [3:0] BCD_NINE = 4'h9;
    localparam logic [3:0] HEX_TEN = 4'hA;

    // Timing
    localparam int CLK_HZ = 20000000;
    localparam int MS_PER_S = 1000;
    localparam int MS_TICK_CYCLES = CLK_HZ / MS_PER_S;
    localparam int NAV_TIMEOUT_S = 2;
    localparam int NAV_TIMEOUT_MS = NAV_TIMEOUT_S * MS_PER_S;
    localparam int RATE_BASE_MS = 10;
    localparam int RATE_MIN_HZ = 1;
    localparam int RATE_MAX_HZ = 100;
    localparam logic [6:0] PERIOD_MAX = 7'(MS_PER_S / (RATE_BASE_MS * RATE_MIN_HZ));
    localparam logic [6:0] PERIOD_MIN = 7'(MS_PER_S / (RATE_BASE_MS * RATE_MAX_HZ));

    // Baud select codes
    localparam logic [2:0] BAUD_9600 = 3'h0;
    localparam logic [2:0] BAUD_115200 = 3'h4;
    localparam logic [2:0] BAUD_921600 = 3'h7;

    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SATS = 8'h04;
    localparam logic [7:0] OFS_HDOP = 8'h08;
    localparam logic [7:0] OFS_HEALTH = 8'h0C;
    localparam logic [7:0] OFS_INT_STAT = 8'h10;
    localparam logic [7:0] OFS_INT_MASK = 8'h14;

    // Interrupt bits
    localparam int INT_DONE = 0;
    localparam int INT_SKIP = 1;
    localparam int INT_FAULT = 2;
    localparam int INT_NAV = 3;
    localparam int INT_W = 4;

    // Sentence layout, by byte step
    localparam int TIME_DIGITS = 13;
    localparam int TIME_W = TIME_DIGITS * 4;
    localparam logic [5:0] ST_DOLLAR = 6'h00;
    localparam logic [5:0] ST_P = 6'h01;
    localparam logic [5:0] ST_TAG = 6'h02;
    localparam logic [5:0] ST_KIND = 6'h05;
    localparam logic [5:0] ST_TIME = 6'h07;
    localparam logic [5:0] ST_TUNIT = 6'h10;
    localparam logic [5:0] ST_TDOT = 6'h11;
    localparam logic [5:0] ST_TFRAC = 6'h14;
    localparam logic [5:0] ST_SATS = 6'h16;
    localparam logic [5:0] ST_VIEW = 6'h19;
    localparam logic [5:0] ST_HDOP = 6'h1C;
    localparam logic [5:0] ST_MODE = 6'h21;
    localparam logic [5:0] ST_FLAGS = 6'h23;
    localparam logic [5:0] ST_STAR = 6'h33;
    localparam logic [5:0] ST_HEX_HI = 6'h34;
    localparam logic [5:0] ST_HEX_LO = 6'h35;
    localparam logic [5:0] ST_CR = 6'h36;
    localparam logic [5:0] ST_LF = 6'h37;

    // Control register, enable in bit 0
    typedef struct packed {
        logic [2:0] baud;
        logic [6:0] period;
        logic mode;
        logic enable;
    } nhf_ctrl_type;
    localparam nhf_ctrl_type CTRL_RESET = '{BAUD_115200, PERIOD_MAX, 1'b0, 1'b0};

    // Values frozen for one sentence
    typedef struct packed {
        logic [TIME_W-1:0] timeBcd;
        logic [7:0] satsUsed;
        logic [7:0] satsView;
        logic [11:0] hdop;
        logic mode;
        logic overflow;
        logic [2:0] fault;
        logic navTimeout;
    } nhf_snap_type;
endpackage

// ---- verilog/nhf_framer.sv ----
module nhf_framer #(
    parameter int MS_CYCLES = nhf_pkg::MS_TICK_CYCLES,
    parameter int SENSORS = 3
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] txData,
    output logic txValid,
    input wire logic txReady,
    output logic [2:0] baudSel,
    output logic irq,
    input wire logic [SENSORS-1:0] sensorFault,
    input wire logic [SENSORS-1:0] sensorReadOk,
    input wire logic navPacketValid,
    input wire logic utcLoad,
    input wire logic [nhf_pkg::TIME_W-1:0] utcTime
);
    import nhf_pkg::*;

    // Hex digit to ASCII
    function automatic logic [7:0] hexChar(input logic [3:0] n);
        hexChar = (n < HEX_TEN) ? CH_ZERO + {4'h0, n} : CH_HEX_A + {4'h0, n};
    endfunction

    // Register decode, shared by write and error paths
    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == OFS_CTRL) || (a == OFS_SATS) || (a == OFS_HDOP) ||
            (a == OFS_HEALTH) || (a == OFS_INT_STAT) || (a == OFS_INT_MASK);
    endfunction

    // Decimal increment of the time counter
    function automatic logic [TIME_W-1:0] bcdInc(input logic [TIME_W-1:0] v);
        logic c;
        bcdInc = v;
        c = 1'b1;
        for (int i = 0; i < TIME_DIGITS; i++) begin
            if (c) begin
                if (v[i*4 +: 4] == BCD_NINE) begin
                    bcdInc[i*4 +: 4] = 4'h0;
                end else begin
                    bcdInc[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
    endfunction

    // Byte of the sentence at a step, with its emit bit on top
    function automatic logic [8:0] sentByte(input logic [5:0] s, input nhf_snap_type q,
        input logic [7:0] sum);
        logic [5:0] r;
        logic [7:0] fl;
        logic [3:0] dg;
        int ti;
        r = s - ST_FLAGS;
        fl = {3'b000, q.navTimeout, q.fault, q.overflow};
        ti = int'(ST_TFRAC) - int'(s) - ((s < ST_TDOT) ? 1 : 0);
        dg = 4'h0;
        sentByte = {1'b1, CH_COMMA};
        if (s == ST_DOLLAR) begin
            sentByte = {1'b1, CH_DOLLAR};
        end else if (s == ST_P) begin
            sentByte = {1'b1, CH_P};
        end else if (s >= ST_TAG && s < ST_KIND) begin
            sentByte = {1'b1, VENDOR_TAG[23 - 8 * int'(s - ST_TAG) -: 8]};
        end else if (s == ST_KIND) begin
            sentByte = {1'b1, CH_H};
        end else if (s == ST_TDOT) begin
            sentByte = {1'b1, CH_DOT};
        end else if (s >= ST_TIME && s <= ST_TFRAC) begin
            // Leading zeros of the whole seconds are dropped
            dg = q.timeBcd[ti*4 +: 4];
            sentByte = {!(s < ST_TUNIT && (q.timeBcd >> (4 * (ti + 1))) == '0 &&
                dg == 4'h0), CH_ZERO + {4'h0, dg}};
        end else if (s == ST_SATS || s == ST_SATS + 6'h01) begin
            dg = (s == ST_SATS) ? q.satsUsed[7:4] : q.satsUsed[3:0];
            sentByte = {1'b1, CH_ZERO + {4'h0, dg}};
        end else if (s == ST_VIEW || s == ST_VIEW + 6'h01) begin
            dg = (s == ST_VIEW) ? q.satsView[7:4] : q.satsView[3:0];
            sentByte = {1'b1, CH_ZERO + {4'h0, dg}};
        end else if (s == ST_HDOP) begin
            sentByte = {q.hdop[11:8] != 4'h0, CH_ZERO + {4'h0, q.hdop[11:8]}};
        end else if (s == ST_HDOP + 6'h01) begin
            sentByte = {1'b1, CH_ZERO + {4'h0, q.hdop[7:4]}};
        end else if (s == ST_HDOP + 6'h02) begin
            sentByte = {1'b1, CH_DOT};
        end else if (s == ST_HDOP + 6'h03) begin
            sentByte = {1'b1, CH_ZERO + {4'h0, q.hdop[3:0]}};
        end else if (s == ST_MODE) begin
            sentByte = {1'b1, CH_ZERO + {7'h00, q.mode}};
        end else if (s >= ST_FLAGS && s < ST_STAR && !r[0]) begin
            // Flags in order, reserved fields read as zero
            sentByte = {1'b1, CH_ZERO + {7'h00, fl[r[3:1]]}};
        end else if (s == ST_STAR) begin
            sentByte = {1'b1, CH_STAR};
        end else if (s == ST_HEX_HI) begin
            sentByte = {1'b1, hexChar(sum[7:4])};
        end else if (s == ST_HEX_LO) begin
            sentByte = {1'b1, hexChar(sum[3:0])};
        end else if (s == ST_CR) begin
            sentByte = {1'b1, CH_CR};
        end else if (s == ST_LF) begin
            sentByte = {1'b1, CH_LF};
        end
    endfunction

    nhf_ctrl_type ctrl_reg;
    nhf_snap_type snap_reg;
    logic [7:0] satsUsed_reg, satsView_reg;
    logic [11:0] hdop_reg;
    logic [TIME_W-1:0] time_reg;
    logic [31:0] msCnt_reg;
    logic [3:0] baseCnt_reg;
    logic [6:0] rateCnt_reg;
    logic [15:0] navMs_reg;
    logic navLinkTimeoutFlag_reg, overflow_reg, active_reg;
    logic [SENSORS-1:0] fault_reg;
    logic [5:0] step_reg;
    logic [7:0] csum_reg;
    logic [INT_W-1:0] intStatus_reg, intMask_reg;
    logic [7:0] txData_reg;
    logic txValid_reg, pready_reg, pslverr_reg, irq_reg;
    logic [31:0] prdata_reg;

    // Time base and rate divider
    wire msTick = (msCnt_reg == 32'(MS_CYCLES - 1));
    wire baseTick = msTick && (baseCnt_reg == 4'(RATE_BASE_MS - 1));
    wire periodHit = baseTick && (rateCnt_reg >= ctrl_reg.period - 7'h01);

    // Sentence sequencing
    wire canLoad = active_reg && (!txValid_reg || txReady);
    wire [8:0] curByte = sentByte(step_reg, snap_reg, csum_reg);
    wire startSent = periodHit && ctrl_reg.enable && !active_reg && !txValid_reg;
    wire skipSent = periodHit && ctrl_reg.enable && !startSent;
    wire sentDone = canLoad && (step_reg == ST_LF);
    wire inSum = (step_reg >= ST_P) && (step_reg < ST_STAR);
    wire navHit = msTick && (navMs_reg == 16'(NAV_TIMEOUT_MS - 1));

    // Register bus decode
    wire apbAccess = psel && penable;
    wire apbDone = apbAccess && pready_reg;
    wire apbWrite = apbDone && pwrite && isMapped(paddr);
    wire intRead = apbDone && !pwrite && (paddr == OFS_INT_STAT);
    wire [6:0] wrPeriod = pwdata[8:2];
    wire [6:0] clampPeriod = (wrPeriod < PERIOD_MIN) ? PERIOD_MIN :
        (wrPeriod > PERIOD_MAX) ? PERIOD_MAX : wrPeriod;
    wire [INT_W-1:0] events = {navHit && !navLinkTimeoutFlag_reg && !navPacketValid,
        |(sensorFault & ~fault_reg), skipSent, sentDone};
    wire [31:0] rdMux =
        (paddr == OFS_CTRL) ? {20'h00000, ctrl_reg} :
        (paddr == OFS_SATS) ? {16'h0000, satsView_reg, satsUsed_reg} :
        (paddr == OFS_HDOP) ? {20'h00000, hdop_reg} :
        (paddr == OFS_HEALTH) ? {26'h0000000, active_reg, navLinkTimeoutFlag_reg,
            fault_reg, overflow_reg} :
        (paddr == OFS_INT_STAT) ? {28'h0000000, intStatus_reg} :
        (paddr == OFS_INT_MASK) ? {28'h0000000, intMask_reg} : 32'h00000000;

    // Millisecond and 10 ms prescalers
    always_ff @(posedge ref_clk) begin
        if (reset || msTick) begin
            msCnt_reg <= 32'h00000000;
        end else begin
            msCnt_reg <= msCnt_reg + 32'h00000001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || baseTick) begin
            baseCnt_reg <= 4'h0;
        end else if (msTick) begin
            baseCnt_reg <= baseCnt_reg + 4'h1;
        end
    end

    // Sentence period in 10 ms steps
    always_ff @(posedge ref_clk) begin
        if (reset || periodHit) begin
            rateCnt_reg <= 7'h00;
        end else if (baseTick) begin
            rateCnt_reg <= rateCnt_reg + 7'h01;
        end
    end

    // Uptime in milliseconds, or UTC once loaded
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            time_reg <= '0;
        end else if (utcLoad) begin
            time_reg <= utcTime;
        end else if (msTick) begin
            time_reg <= bcdInc(time_reg);
        end
    end

    // Navigation link silence watchdog
    always_ff @(posedge ref_clk) begin
        if (reset || navPacketValid) begin
            navMs_reg <= 16'h0000;
            navLinkTimeoutFlag_reg <= 1'b0;
        end else if (msTick && !navLinkTimeoutFlag_reg) begin
            navMs_reg <= navMs_reg + 16'h0001;
            navLinkTimeoutFlag_reg <= navHit;
        end
    end

    // Sensor fault flags
    for (genvar g = 0; g < SENSORS; g++) begin : gFault
        always_ff @(posedge ref_clk) begin
            if (reset) begin
                fault_reg[g] <= 1'b0;
            end else if (sensorFault[g]) begin
                fault_reg[g] <= 1'b1;
            end else if (sensorReadOk[g]) begin
                fault_reg[g] <= 1'b0;
            end
        end
    end

    // Sticky overflow, cleared only by reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            overflow_reg <= 1'b0;
        end else if (skipSent) begin
            overflow_reg <= 1'b1;
        end
    end

    // Sequencer state
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            active_reg <= 1'b0;
            step_reg <= ST_DOLLAR;
        end else if (startSent) begin
            active_reg <= 1'b1;
            step_reg <= ST_DOLLAR;
        end else if (canLoad) begin
            active_reg <= !sentDone;
            step_reg <= step_reg + 6'h01;
        end
    end

    // Frozen field values and running checksum
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            snap_reg <= '0;
            csum_reg <= 8'h00;
        end else if (startSent) begin
            snap_reg <= '{time_reg, satsUsed_reg, satsView_reg, hdop_reg, ctrl_reg.mode,
                overflow_reg, fault_reg, navLinkTimeoutFlag_reg};
            csum_reg <= 8'h00;
        end else if (canLoad && curByte[8] && inSum) begin
            csum_reg <= csum_reg ^ curByte[7:0];
        end
    end

    // Byte stream output, held until taken
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            txValid_reg <= 1'b0;
            txData_reg <= 8'h00;
        end else if (canLoad && curByte[8]) begin
            txValid_reg <= 1'b1;
            txData_reg <= curByte[7:0];
        end else if (txReady) begin
            txValid_reg <= 1'b0;
        end
    end

    // Software registers; the bus is the only configuration path
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_reg <= CTRL_RESET;
            satsUsed_reg <= 8'h00;
            satsView_reg <= 8'h00;
            hdop_reg <= 12'h000;
            intMask_reg <= '0;
        end else if (apbWrite) begin
            if (paddr == OFS_CTRL) begin
                ctrl_reg <= '{pwdata[11:9], clampPeriod, pwdata[1], pwdata[0]};
            end
            if (paddr == OFS_SATS) begin
                satsUsed_reg <= pwdata[7:0];
                satsView_reg <= pwdata[15:8];
            end
            if (paddr == OFS_HDOP) begin
                hdop_reg <= pwdata[11:0];
            end
            if (paddr == OFS_INT_MASK) begin
                intMask_reg <= pwdata[INT_W-1:0];
            end
        end
    end

    // Interrupt status, read clears only what was returned
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            intStatus_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            intStatus_reg <= (intRead ? intStatus_reg & ~prdata_reg[INT_W-1:0] :
                intStatus_reg) | events;
            irq_reg <= |(intStatus_reg & intMask_reg);
        end
    end

    // Bus answer after one wait state
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= apbAccess && !pready_reg;
            pslverr_reg <= apbAccess && !pready_reg && !isMapped(paddr);
            if (apbAccess && !pready_reg) begin
                prdata_reg <= pwrite ? 32'h00000000 : rdMux;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign txData = txData_reg;
    assign txValid = txValid_reg;
    assign baudSel = ctrl_reg.baud;
    assign irq = irq_reg;

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    a_start_dollar: assert property ($rose(active_reg) |=> txValid_reg &&
        txData_reg == CH_DOLLAR) else $error("sentence does not open with dollar");
    a_cr_then_lf: assert property (txValid_reg && txReady && txData_reg == CH_CR
        |=> txValid_reg && txData_reg == CH_LF) else $error("LF does not follow CR");
    a_hex_after_star: assert property (txValid_reg && txReady && txData_reg == CH_STAR
        |=> txValid_reg && txData_reg == hexChar(csum_reg[7:4]))
        else $error("checksum high digit wrong");
    a_skip_overflow: assert property (skipSent |=> overflow_reg)
        else $error("skipped sentence did not flag overflow");
    a_overflow_hold: assert property (overflow_reg |=> overflow_reg)
        else $error("overflow flag cleared");
    a_fault_hold: assert property (fault_reg[1] && !sensorReadOk[1] |=> fault_reg[1])
        else $error("fault flag dropped without good read");
    a_fault_set: assert property (sensorFault[0] |=> fault_reg[0])
        else $error("fault flag not set");
    a_nav_clear: assert property (navPacketValid |=> !navLinkTimeoutFlag_reg)
        else $error("timeout flag not cleared by packet");
    a_period_range: assert property (ctrl_reg.period >= PERIOD_MIN &&
        ctrl_reg.period <= PERIOD_MAX) else $error("sentence period out of range");
    a_irq_level: assert property (##1 irq_reg == $past(|(intStatus_reg & intMask_reg)))
        else $error("interrupt output does not follow status");
    a_sentence_ends: assert property (sentDone |=> !active_reg ##0 txData_reg == CH_LF)
        else $error("sentence did not end on LF");
endmodule

// ---- verif/nhf_host_model.sv ----
module nhf_host_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady,
    input wire logic stall,
    output logic gotByte,
    output logic [7:0] gotData
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] slowCnt;
    // Takes a byte each cycle, or every fourth cycle while stalling
    always @(posedge ref_clk) begin
        slowCnt <= reset ? 2'h0 : slowCnt + 2'h1;
        txReady <= !stall || (slowCnt == 2'h3);
        gotByte <= !reset && txValid && txReady;
        gotData <= txData;
    end
endmodule

// ---- verif/test_nmea_health_sentence_framer.sv ----
module test_nmea_health_sentence_framer;
    timeunit 1ns;
    timeprecision 1ns;
    import nhf_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0, sent = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, txValid, txReady, irq, gotByte, err;
    logic [7:0] txData, gotData;
    logic [2:0] baudSel, sensorFault = 3'h0, sensorReadOk = 3'h0, faultE = 3'h0;
    logic navPacketValid = 1'b0, utcLoad = 1'b0, ovfE = 1'b0, navE = 1'b0;
    logic [TIME_W-1:0] utcTime = '0;
    logic [7:0] rx[$];
    int n_mismatch = 0, compares = 0, seed = 32'hf04b, cyc = 0, lastStart = 0, gap = 0;

    nhf_framer #(.MS_CYCLES(10)) dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .txData(txData), .txValid(txValid),
        .txReady(txReady), .baudSel(baudSel), .irq(irq), .sensorFault(sensorFault),
        .sensorReadOk(sensorReadOk), .navPacketValid(navPacketValid), .utcLoad(utcLoad),
        .utcTime(utcTime));
    nhf_host_model host (.ref_clk(ref_clk), .reset(reset), .txData(txData),
        .txValid(txValid), .txReady(txReady), .stall(stall), .gotByte(gotByte),
        .gotData(gotData));

    initial forever #25 ref_clk = ~ref_clk;

    // Collects one sentence, restarting at each dollar sign
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (gotByte) begin
            if (gotData == CH_DOLLAR) begin
                rx = {};
                sent = 1'b0;
                gap = cyc - lastStart;
                lastStart = cyc;
            end
            rx.push_back(gotData);
            if (gotData == CH_LF) sent = 1'b1;
        end
    end

    task finish_test;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task cmp_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_word({24'h0, got}, {24'h0, exp});
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One-cycle pulse: 0 fault, 1 good read, 2 nav packet
    task pulse(input int kind, input int b);
        @(posedge ref_clk);
        if (kind == 0) sensorFault[b] <= 1'b1;
        if (kind == 1) sensorReadOk[b] <= 1'b1;
        if (kind == 2) navPacketValid <= 1'b1;
        @(posedge ref_clk);
        sensorFault <= 3'h0;
        sensorReadOk <= 3'h0;
        navPacketValid <= 1'b0;
    endtask

    task get_sentence;
        int n;
        n = 0;
        // Skip any sentence framed before this call
        repeat (4) @(posedge ref_clk);
        while (sent !== 1'b1 && n < 5000) begin
            @(posedge ref_clk);
            n++;
        end
        while (sent !== 1'b0 && n < 5000) begin
            @(posedge ref_clk);
            n++;
        end
        while (sent !== 1'b1 && n < 5000) begin
            @(posedge ref_clk);
            n++;
        end
        cmp_word(n < 5000, 1);
    endtask

    function automatic logic [7:0] hx(input logic [3:0] v);
        return (v < 4'hA) ? 8'h30 + v : 8'h41 + v - 8'hA;
    endfunction

    task check_sentence(input logic [15:0] sats, input logic [11:0] hd, input logic m);
        string hdr, tail, hs;
        logic [7:0] sum;
        int j;
        get_sentence;
        hdr = $sformatf("$P%sH,", VENDOR_TAG);
        hs = (hd[11:8] != 4'h0) ? $sformatf("%0h%0h.%0h", hd[11:8], hd[7:4], hd[3:0])
            : $sformatf("%0h.%0h", hd[7:4], hd[3:0]);
        sum = 8'h00;
        for (j = 1; j < rx.size() - 5; j++) sum ^= rx[j];
        j = 8;
        while (j < rx.size() && rx[j] != CH_COMMA) j++;
        cmp_byte(rx[j-4], CH_DOT);
        tail = $sformatf(",%02h,%02h,%s,%0d,%0d,%0d,%0d,%0d,%0d,0,0,0,*%s%s", sats[7:0],
            sats[15:8], hs, m, ovfE, faultE[0], faultE[1], faultE[2], navE,
            {hx(sum[7:4]), hx(sum[3:0])}, 16'h0D0A);
        for (int k = 0; k < 7; k++) cmp_byte(rx[k], hdr[k]);
        for (int k = 0; k < tail.len(); k++) cmp_byte(rx[j+k], tail[k]);
        cmp_word(rx.size(), j + tail.len());
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        n_mismatch++;
        finish_test;
    end

    initial begin
        logic [2:0] b;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        apb(1'b0, OFS_CTRL, 32'h0);
        cmp_word(rd, 32'h990);
        cmp_word(baudSel, BAUD_115200);
        apb(1'b0, 8'h18, 32'h0);
        cmp_word(err, 1);
        // Both modes, random baud, small and large HDOP
        for (int m = 0; m < 2; m++) begin
            b = 3'($random(seed));
            apb(1'b1, OFS_SATS, 32'h0507);
            apb(1'b1, OFS_HDOP, m ? 32'h015 : 32'h123);
            apb(1'b1, OFS_CTRL, {20'h0, b, 7'h01, 1'(m), 1'b1});
            @(posedge ref_clk);
            cmp_word(baudSel, b);
            utcTime <= 52'h123000;
            utcLoad <= 1'b1;
            @(posedge ref_clk);
            utcLoad <= 1'b0;
            check_sentence(16'h0507, m ? 12'h015 : 12'h123, 1'(m));
            cmp_word({rx[7], rx[8], rx[9]}, 32'h313233);
            get_sentence;
            cmp_word(gap, 100);
        end
        // Each sensor fault raises the interrupt and holds until a good read
        apb(1'b1, OFS_INT_MASK, 32'h4);
        for (int s = 0; s < 3; s++) begin
            pulse(0, s);
            faultE[s] = 1'b1;
            repeat (3) @(posedge ref_clk);
            cmp_word(irq, 1);
            apb(1'b0, OFS_INT_STAT, 32'h0);
            cmp_word(rd & 32'h4, 32'h4);
            repeat (3) @(posedge ref_clk);
            cmp_word(irq, 0);
            check_sentence(16'h0507, 12'h015, 1'b1);
            pulse(1, s);
            faultE[s] = 1'b0;
            check_sentence(16'h0507, 12'h015, 1'b1);
        end
        // Slow host forces skipped sentences, which stay intact
        stall <= 1'b1;
        repeat (300) @(posedge ref_clk);
        ovfE = 1'b1;
        check_sentence(16'h0507, 12'h015, 1'b1);
        stall <= 1'b0;
        apb(1'b0, OFS_HEALTH, 32'h0);
        cmp_word(rd & 32'h1, 32'h1);
        // Navigation silence sets the timeout flag, a packet clears it
        pulse(2, 0);
        repeat (19900) @(posedge ref_clk);
        apb(1'b0, OFS_HEALTH, 32'h0);
        cmp_word(rd & 32'h10, 32'h0);
        repeat (300) @(posedge ref_clk);
        apb(1'b0, OFS_HEALTH, 32'h0);
        cmp_word(rd & 32'h10, 32'h10);
        navE = 1'b1;
        check_sentence(16'h0507, 12'h015, 1'b1);
        pulse(2, 0);
        navE = 1'b0;
        apb(1'b0, OFS_HEALTH, 32'h0);
        cmp_word(rd & 32'h11, 32'h1);
        finish_test;
    end
endmodule
